// ===== hw/ep_status_pkg.sv
// What this block does
// - read-only bit: last control packet DATA1
// - read-only bit: last control token was SETUP
// - flag IN-first when receive done while transmit done flag still set
// - writing one clears IN-first flag; zero ignored
// - control receive byte count, kept across reset
// - endpoint 2 answers IN only while active
// - endpoint 1 answers IN only while active
// - endpoint 2 halt bit forces STALL replies
// - endpoint 1 halt bit forces STALL replies
// - control OUT/SETUP bytes fill eight receive registers
// - control transmit bytes sent on next IN
// - shared transmit bytes go to selected endpoint
// - transmit done flag set after ACKed packet
// - endpoint 2 selected wrongly answers NAK
package ep_status_pkg;
	localparam int unsigned ADDR_W              = 7;
	localparam int unsigned BUF_DEPTH           = 8;
	localparam logic [6:0]  OFF_DEVICE_STATUS   = 7'h00;
	localparam logic [6:0]  OFF_EP_ENABLE_STALL = 7'h04;
	localparam logic [6:0]  OFF_CTL_FLAGS       = 7'h08;
	localparam logic [6:0]  OFF_IRQ_STATUS      = 7'h0C;
	localparam logic [6:0]  OFF_IRQ_MASK        = 7'h10;
	localparam logic [6:0]  OFF_CTL_BUF         = 7'h20;
	localparam logic [6:0]  OFF_SHARED_BUF      = 7'h40;
	// device_status fields
	localparam int unsigned DS_RX_TOGGLE_BIT    = 7;
	localparam int unsigned DS_SETUP_BIT        = 6;
	localparam int unsigned DS_IN_FIRST_BIT     = 5;
	localparam int unsigned DS_IN_FIRST_CLR_BIT = 4;
	// endpoint_enable_stall_control fields
	localparam int unsigned EC_EP2_ACTIVE_BIT   = 7;
	localparam int unsigned EC_EP1_ACTIVE_BIT   = 6;
	localparam int unsigned EC_EP2_HALT_BIT     = 5;
	localparam int unsigned EC_EP1_HALT_BIT     = 4;
	// control flag register: read flags, write one to clear
	localparam int unsigned CF_RX_DONE_BIT      = 1;
	localparam int unsigned CF_TX_DONE_BIT      = 0;
	// interrupt status and mask layout
	localparam int unsigned IRQ_W               = 3;
	localparam int unsigned IRQ_RX_DONE_BIT     = 0;
	localparam int unsigned IRQ_TX_DONE_BIT     = 1;
	localparam int unsigned IRQ_IN_FIRST_BIT    = 2;
	localparam logic [2:0]  IRQ_MASK_RESET      = 3'h0;
	// token kinds from the protocol engine
	localparam logic [1:0]  TOK_OUT             = 2'h0;
	localparam logic [1:0]  TOK_IN              = 2'h1;
	localparam logic [1:0]  TOK_SETUP           = 2'h2;
	localparam logic [3:0]  EP_CTL              = 4'h0;
	localparam logic [3:0]  EP_ONE              = 4'h1;
	localparam logic [3:0]  EP_TWO              = 4'h2;
	localparam logic [31:0] READ_ZERO           = 32'h0000_0000;

	typedef enum logic [2:0] {
		RESP_NONE,
		RESP_NAK,
		RESP_STALL,
		RESP_DATA,
		RESP_ACCEPT
	} resp_t;
endpackage : ep_status_pkg

// ===== hw/token_responder.sv
`timescale 1ns/1ps
module token_responder
	import ep_status_pkg::*;
(
	input  wire logic [1:0] tok_kind_in,
	input  wire logic [3:0] tok_ep_in,
	input  wire logic       ep1_active_in,
	input  wire logic       ep2_active_in,
	input  wire logic       ep1_force_halt_in,
	input  wire logic       ep2_force_halt_in,
	input  wire logic       target_select_in,
	input  wire logic       shared_tx_enable_in,
	input  wire logic       shared_tx_done_in,
	input  wire logic       ctl_tx_enable_in,
	input  wire logic       ctl_rx_enable_in,
	input  wire logic       ctl_tx_done_in,
	input  wire logic       ctl_rx_done_in,
	output resp_t           resp_out
);
	logic is_in;
	logic shared_ready;

	always_comb begin
		is_in        = (tok_kind_in == TOK_IN);
		shared_ready = shared_tx_enable_in && !shared_tx_done_in;
		resp_out     = RESP_NONE;
		case (tok_ep_in)
			EP_CTL: begin
				if (tok_kind_in == TOK_SETUP) begin
					resp_out = RESP_ACCEPT;
				end else if (is_in) begin
					resp_out = (ctl_tx_enable_in && !ctl_tx_done_in) ? RESP_DATA : RESP_NAK;
				end else begin
					resp_out = (ctl_rx_enable_in && !ctl_rx_done_in) ? RESP_ACCEPT : RESP_NAK;
				end
			end
			EP_ONE: begin
				if (ep1_force_halt_in) begin
					resp_out = RESP_STALL;
				end else if (is_in && ep1_active_in) begin
					resp_out = (shared_ready && !target_select_in) ? RESP_DATA : RESP_NAK;
				end
			end
			EP_TWO: begin
				if (ep2_force_halt_in) begin
					resp_out = RESP_STALL;
				end else if (is_in && ep2_active_in) begin
					resp_out = (shared_ready && target_select_in) ? RESP_DATA : RESP_NAK;
				end
			end
			default: begin
				resp_out = RESP_NONE;
			end
		endcase
	end
endmodule : token_responder

// ===== hw/usb_device_endpoint_status_ctrl.sv
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module usb_device_endpoint_status_ctrl
	import ep_status_pkg::*;
#(
	parameter int unsigned DEPTH = BUF_DEPTH
) (
	input  wire logic              sys_clk_in,
	input  wire logic              rst_in,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] avs_address_in,
	input  wire logic              avs_read_in,
	input  wire logic              avs_write_in,
	input  wire logic [31:0]       avs_writedata_in,
	input  wire logic [3:0]        avs_byteenable_in,
	output logic      [31:0]       avs_readdata_out,
	output logic                   avs_waitrequest_out,
	output logic                   irq_out,
	// protocol engine side, same clock
	input  wire logic              tok_valid_in,
	input  wire logic [1:0]        tok_kind_in,
	input  wire logic [3:0]        tok_ep_in,
	input  wire logic              rx_byte_valid_in,
	input  wire logic [7:0]        rx_byte_in,
	input  wire logic              rx_done_in,
	input  wire logic              rx_data1_in,
	input  wire logic              tx_ack_in,
	input  wire logic              tx_ready_in,
	// control bits held in neighbouring registers
	input  wire logic              shared_buffer_target_select_in,
	input  wire logic              shared_tx_enable_in,
	input  wire logic              shared_tx_done_in,
	input  wire logic [3:0]        shared_tx_count_in,
	input  wire logic              ctl_tx_enable_in,
	input  wire logic              ctl_rx_enable_in,
	input  wire logic [3:0]        ctl_tx_count_in,
	// handshake and data out
	output logic                   hs_valid_out,
	output resp_t                  hs_code_out,
	output logic                   tx_valid_out,
	output logic      [7:0]        tx_byte_out,
	output logic                   tx_last_out
);
	if (DEPTH != BUF_DEPTH) begin : g_depth_bad
		$error("buffer depth must be eight");
	end

	typedef struct packed {
		logic                 wait_req;
		logic [31:0]          rdata;
		logic                 ctl_rx_toggle;
		logic                 setup_token_seen;
		logic                 in_before_out_flag;
		logic [3:0]           ctl_rx_byte_count;
		logic                 ep2_active;
		logic                 ep1_active;
		logic                 ep2_force_halt;
		logic                 ep1_force_halt;
		logic                 ctl_rx_done_flag;
		logic                 ctl_tx_done_flag;
		logic [IRQ_W-1:0]     irq_status;
		logic [IRQ_W-1:0]     irq_mask;
		logic                 irq;
		logic [7:0][7:0]      ctl_rx_bytes;
		logic [7:0][7:0]      ctl_tx_bytes;
		logic [7:0][7:0]      shared_in_tx_bytes;
		logic [3:0]           rx_ptr;
		logic                 rx_armed;
		logic                 rx_setup_pend;
		logic                 in_ctl_pend;
		logic                 hs_valid;
		resp_t                hs_code;
		logic                 tx_busy;
		logic                 tx_shared;
		logic [3:0]           tx_idx;
		logic [3:0]           tx_len;
		logic                 tx_valid;
		logic [7:0]           tx_byte;
		logic                 tx_last;
	} state_t;

	state_t s_q;
	state_t s_d;
	resp_t  resp;

	function automatic logic [7:0] pick_byte(input logic [7:0][7:0] bank, input logic [3:0] idx);
		pick_byte = bank[idx[2:0]];
	endfunction : pick_byte

	function automatic logic [3:0] clip_len(input logic [3:0] len);
		clip_len = (len > 4'h8) ? 4'h8 : len;
	endfunction : clip_len

	token_responder u_resp (
		.tok_kind_in         (tok_kind_in),
		.tok_ep_in           (tok_ep_in),
		.ep1_active_in       (s_q.ep1_active),
		.ep2_active_in       (s_q.ep2_active),
		.ep1_force_halt_in   (s_q.ep1_force_halt),
		.ep2_force_halt_in   (s_q.ep2_force_halt),
		.target_select_in    (shared_buffer_target_select_in),
		.shared_tx_enable_in (shared_tx_enable_in),
		.shared_tx_done_in   (shared_tx_done_in),
		.ctl_tx_enable_in    (ctl_tx_enable_in),
		.ctl_rx_enable_in    (ctl_rx_enable_in),
		.ctl_tx_done_in      (s_q.ctl_tx_done_flag),
		.ctl_rx_done_in      (s_q.ctl_rx_done_flag),
		.resp_out            (resp)
	);

	logic                  req;
	logic                  take;
	logic                  wr;
	logic                  rd;
	logic [ADDR_W-1:0]     word_addr;
	logic [2:0]            slot;
	logic [7:0]            wbyte;
	logic                  rx_event;
	logic                  tx_event;
	logic                  in_first_event;
	logic                  in_first_clear;
	logic [IRQ_W-1:0]      irq_set;
	logic [31:0]           rmux;

	always_comb begin
		s_d            = s_q;
		req            = avs_read_in || avs_write_in;
		take           = req && s_q.wait_req == 1'b0;
		wr             = take && avs_write_in && avs_byteenable_in[0];
		rd             = take && avs_read_in;
		word_addr      = {avs_address_in[ADDR_W-1:2], 2'b00};
		slot           = avs_address_in[4:2];
		wbyte          = avs_writedata_in[7:0];
		rx_event       = rx_done_in && s_q.rx_armed;
		tx_event       = tx_ack_in && s_q.in_ctl_pend;
		in_first_event = rx_event && s_q.ctl_tx_done_flag;
		in_first_clear = wr && word_addr == OFF_DEVICE_STATUS && wbyte[DS_IN_FIRST_CLR_BIT];
		irq_set        = '0;
		irq_set[IRQ_RX_DONE_BIT]  = rx_event;
		irq_set[IRQ_TX_DONE_BIT]  = tx_event;
		irq_set[IRQ_IN_FIRST_BIT] = in_first_event;

		// one wait cycle, then a single answer cycle
		s_d.wait_req = !(req && s_q.wait_req);

		// read data is prepared while waitrequest is still high
		rmux = READ_ZERO;
		if (word_addr == OFF_DEVICE_STATUS) begin
			rmux[DS_RX_TOGGLE_BIT] = s_q.ctl_rx_toggle;
			rmux[DS_SETUP_BIT]     = s_q.setup_token_seen;
			rmux[DS_IN_FIRST_BIT]  = s_q.in_before_out_flag;
			rmux[3:0]              = s_q.ctl_rx_byte_count;
		end else if (word_addr == OFF_EP_ENABLE_STALL) begin
			rmux[EC_EP2_ACTIVE_BIT] = s_q.ep2_active;
			rmux[EC_EP1_ACTIVE_BIT] = s_q.ep1_active;
			rmux[EC_EP2_HALT_BIT]   = s_q.ep2_force_halt;
			rmux[EC_EP1_HALT_BIT]   = s_q.ep1_force_halt;
		end else if (word_addr == OFF_CTL_FLAGS) begin
			rmux[CF_RX_DONE_BIT] = s_q.ctl_rx_done_flag;
			rmux[CF_TX_DONE_BIT] = s_q.ctl_tx_done_flag;
		end else if (word_addr == OFF_IRQ_STATUS) begin
			rmux[IRQ_W-1:0] = s_q.irq_status;
		end else if (word_addr == OFF_IRQ_MASK) begin
			rmux[IRQ_W-1:0] = s_q.irq_mask;
		end else if (avs_address_in[ADDR_W-1:5] == OFF_CTL_BUF[ADDR_W-1:5]) begin
			// transmit side is write-only, reads show received bytes
			rmux[7:0] = s_q.ctl_rx_bytes[slot];
		end
		if (req && s_q.wait_req) begin
			s_d.rdata = rmux;
		end

		// register writes land on the edge after the answer cycle, when waitrequest rises again
		if (wr) begin
			if (word_addr == OFF_EP_ENABLE_STALL) begin
				s_d.ep2_active     = wbyte[EC_EP2_ACTIVE_BIT];
				s_d.ep1_active     = wbyte[EC_EP1_ACTIVE_BIT];
				s_d.ep2_force_halt = wbyte[EC_EP2_HALT_BIT];
				s_d.ep1_force_halt = wbyte[EC_EP1_HALT_BIT];
			end
			if (word_addr == OFF_CTL_FLAGS) begin
				if (wbyte[CF_RX_DONE_BIT]) begin
					s_d.ctl_rx_done_flag = 1'b0;
				end
				if (wbyte[CF_TX_DONE_BIT]) begin
					s_d.ctl_tx_done_flag = 1'b0;
				end
			end
			if (word_addr == OFF_IRQ_MASK) begin
				s_d.irq_mask = wbyte[IRQ_W-1:0];
			end
			if (avs_address_in[ADDR_W-1:5] == OFF_CTL_BUF[ADDR_W-1:5]) begin
				s_d.ctl_tx_bytes[slot] = wbyte;
			end
			if (avs_address_in[ADDR_W-1:5] == OFF_SHARED_BUF[ADDR_W-1:5]) begin
				s_d.shared_in_tx_bytes[slot] = wbyte;
			end
		end
		if (in_first_clear) begin
			s_d.in_before_out_flag = 1'b0;
		end
		if (in_first_event) begin
			s_d.in_before_out_flag = 1'b1;
		end

		// read clears status; a set in the same cycle survives
		if (rd && word_addr == OFF_IRQ_STATUS) begin
			s_d.irq_status = '0;
		end
		s_d.irq_status = s_d.irq_status | irq_set;
		s_d.irq        = |(s_d.irq_status & s_d.irq_mask);

		// token handling
		s_d.hs_valid = 1'b0;
		if (tok_valid_in) begin
			s_d.hs_valid = (resp != RESP_NONE);
			s_d.hs_code  = resp;
			s_d.rx_armed = 1'b0;
			if (tok_ep_in == EP_CTL && resp == RESP_ACCEPT) begin
				s_d.rx_armed      = 1'b1;
				s_d.rx_ptr        = 4'h0;
				s_d.rx_setup_pend = (tok_kind_in == TOK_SETUP);
			end
			if (resp == RESP_DATA) begin
				s_d.tx_busy     = 1'b1;
				s_d.tx_valid    = 1'b0;
				s_d.tx_idx      = 4'h0;
				s_d.tx_shared   = (tok_ep_in != EP_CTL);
				s_d.tx_len      = clip_len((tok_ep_in == EP_CTL) ? ctl_tx_count_in : shared_tx_count_in);
				s_d.in_ctl_pend = (tok_ep_in == EP_CTL);
			end
		end

		// bytes beyond the eighth are dropped, and the count stops at eight
		if (rx_byte_valid_in && s_q.rx_armed && s_q.rx_ptr < 4'h8) begin
			s_d.ctl_rx_bytes[s_q.rx_ptr[2:0]] = rx_byte_in;
			s_d.rx_ptr = s_q.rx_ptr + 4'h1;
		end

		if (rx_event) begin
			s_d.rx_armed          = 1'b0;
			s_d.ctl_rx_done_flag  = 1'b1;
			s_d.ctl_rx_toggle     = rx_data1_in;
			s_d.setup_token_seen  = s_q.rx_setup_pend;
			s_d.ctl_rx_byte_count = s_q.rx_ptr;
		end
		if (tx_event) begin
			s_d.ctl_tx_done_flag = 1'b1;
			s_d.in_ctl_pend      = 1'b0;
		end

		// outgoing byte stream, held while the engine stalls
		if (s_q.tx_busy && (!s_q.tx_valid || tx_ready_in)) begin
			if (s_q.tx_idx < s_q.tx_len) begin
				s_d.tx_valid = 1'b1;
				s_d.tx_byte  = s_q.tx_shared ? pick_byte(s_q.shared_in_tx_bytes, s_q.tx_idx)
				                             : pick_byte(s_q.ctl_tx_bytes, s_q.tx_idx);
				s_d.tx_last  = (s_q.tx_idx == s_q.tx_len - 4'h1);
				s_d.tx_idx   = s_q.tx_idx + 4'h1;
			end else begin
				s_d.tx_valid = 1'b0;
				s_d.tx_last  = 1'b0;
				s_d.tx_busy  = 1'b0;
			end
		end

		if (rst_in) begin
			s_d.wait_req           = 1'b1;
			s_d.rdata              = READ_ZERO;
			s_d.ctl_rx_toggle      = 1'b0;
			s_d.setup_token_seen   = 1'b0;
			s_d.in_before_out_flag = 1'b0;
			s_d.ctl_rx_byte_count  = s_q.ctl_rx_byte_count;
			s_d.ep2_active         = 1'b0;
			s_d.ep1_active         = 1'b0;
			s_d.ep2_force_halt     = 1'b0;
			s_d.ep1_force_halt     = 1'b0;
			s_d.ctl_rx_done_flag   = 1'b0;
			s_d.ctl_tx_done_flag   = 1'b0;
			s_d.irq_status         = '0;
			s_d.irq_mask           = IRQ_MASK_RESET;
			s_d.irq                = 1'b0;
			s_d.rx_ptr             = 4'h0;
			s_d.rx_armed           = 1'b0;
			s_d.rx_setup_pend      = 1'b0;
			s_d.in_ctl_pend        = 1'b0;
			s_d.hs_valid           = 1'b0;
			s_d.hs_code            = RESP_NONE;
			s_d.tx_busy            = 1'b0;
			s_d.tx_shared          = 1'b0;
			s_d.tx_idx             = 4'h0;
			s_d.tx_len             = 4'h0;
			s_d.tx_valid           = 1'b0;
			s_d.tx_byte            = 8'h00;
			s_d.tx_last            = 1'b0;
			// buffer contents are not cleared by reset
		end
	end

	always_ff @(posedge sys_clk_in) begin
		s_q <= s_d;
	end

	assign avs_readdata_out    = s_q.rdata;
	assign avs_waitrequest_out = s_q.wait_req;
	assign irq_out             = s_q.irq;
	assign hs_valid_out        = s_q.hs_valid;
	assign hs_code_out         = s_q.hs_code;
	assign tx_valid_out        = s_q.tx_valid;
	assign tx_byte_out         = s_q.tx_byte;
	assign tx_last_out         = s_q.tx_last;
endmodule : usb_device_endpoint_status_ctrl

// ===== dv/usb_device_endpoint_status_ctrl_checker.sv
`timescale 1ns/1ps
module usb_device_endpoint_status_ctrl_checker
	import ep_status_pkg::*;
(
	input wire logic       sys_clk_in,
	input wire logic       rst_in,
	input wire logic       avs_read_in,
	input wire logic       avs_write_in,
	input wire logic       avs_waitrequest_out,
	input wire logic       tok_valid_in,
	input wire logic [1:0] tok_kind_in,
	input wire logic [3:0] tok_ep_in,
	input wire logic       tx_ready_in,
	input wire logic       shared_buffer_target_select_in,
	input wire logic       shared_tx_enable_in,
	input wire logic       shared_tx_done_in,
	input wire logic [3:0] shared_tx_count_in,
	input wire logic       ctl_tx_enable_in,
	input wire logic       ctl_rx_enable_in,
	input wire logic [3:0] ctl_tx_count_in,
	input wire logic       hs_valid_out,
	input wire resp_t      hs_code_out,
	input wire logic       tx_valid_out,
	input wire logic [7:0] tx_byte_out,
	input wire logic       tx_last_out
);
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	wire ep0_tok = tok_valid_in && tok_ep_in == EP_CTL;
	wire ep2_in  = tok_valid_in && tok_ep_in == EP_TWO && tok_kind_in == TOK_IN;
	a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("waitrequest not low after one cycle");
	a_bus_release: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	a_setup_accept: assert property (ep0_tok && tok_kind_in == TOK_SETUP |=> hs_valid_out && hs_code_out == RESP_ACCEPT)
		else $error("setup not accepted");
	a_ctl_in_nak: assert property (ep0_tok && tok_kind_in == TOK_IN && !ctl_tx_enable_in |=> hs_valid_out && hs_code_out == RESP_NAK)
		else $error("control in without enable not refused");
	a_ctl_out_nak: assert property (ep0_tok && tok_kind_in == TOK_OUT && !ctl_rx_enable_in |=> hs_valid_out && hs_code_out == RESP_NAK)
		else $error("control out without enable not refused");
	a_wrong_select: assert property (ep2_in && !shared_buffer_target_select_in && shared_tx_enable_in && !shared_tx_done_in
		|=> !(hs_valid_out && hs_code_out == RESP_DATA))
		else $error("endpoint two sent data while buffer selected for one");
	a_far_ep_silent: assert property (tok_valid_in && tok_ep_in > EP_TWO |=> !hs_valid_out)
		else $error("answer to unknown endpoint");
	a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out))
		else $error("tx byte changed while stalled");
	a_tx_start: assert property (hs_valid_out && hs_code_out == RESP_DATA && ctl_tx_count_in != 4'h0 && shared_tx_count_in != 4'h0
		|=> tx_valid_out)
		else $error("data handshake without first byte");
	a_tx_end: assert property (tx_valid_out && tx_ready_in && tx_last_out |=> !tx_valid_out)
		else $error("bytes after last");
endmodule : usb_device_endpoint_status_ctrl_checker

// ===== dv/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model
	import ep_status_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       slow_in,
	output logic            tok_valid_out,
	output logic [1:0]      tok_kind_out,
	output logic [3:0]      tok_ep_out,
	output logic            rx_byte_valid_out,
	output logic [7:0]      rx_byte_out,
	output logic            rx_done_out,
	output logic            rx_data1_out,
	output logic            tx_ack_out,
	output logic            tx_ready_out
);
	initial begin
		{tok_valid_out, tok_kind_out, tok_ep_out, rx_byte_valid_out, rx_byte_out} = '0;
		{rx_done_out, rx_data1_out, tx_ack_out, tx_ready_out} = '0;
	end
	// slow host stalls every other cycle
	always @(posedge sys_clk_in) begin
		tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
	end
	task automatic token(input logic [1:0] k, input logic [3:0] e);
		@(posedge sys_clk_in);
		tok_valid_out <= 1'b1;
		tok_kind_out  <= k;
		tok_ep_out    <= e;
		@(posedge sys_clk_in);
		tok_valid_out <= 1'b0;
		tok_kind_out  <= ~k;
		tok_ep_out    <= ~e;
	endtask : token
	task automatic rx_packet(input logic [7:0] b [8], input int n, input logic d1);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_in);
			rx_byte_valid_out <= 1'b1;
			rx_byte_out       <= b[i];
		end
		@(posedge sys_clk_in);
		rx_byte_valid_out <= 1'b0;
		rx_byte_out       <= ~rx_byte_out;
		rx_done_out       <= 1'b1;
		rx_data1_out      <= d1;
		@(posedge sys_clk_in);
		rx_done_out  <= 1'b0;
		rx_data1_out <= ~d1;
	endtask : rx_packet
	task automatic ack();
		@(posedge sys_clk_in);
		tx_ack_out <= 1'b1;
		@(posedge sys_clk_in);
		tx_ack_out <= 1'b0;
	endtask : ack
endmodule : usb_host_model

// ===== dv/test_usb_device_endpoint_status_ctrl.sv
`timescale 1ns/1ps
module test_usb_device_endpoint_status_ctrl
	import ep_status_pkg::*;
;
	logic        sys_clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out, irq_out, slow;
	logic [6:0]  avs_address_in;
	logic [31:0] avs_writedata_in, avs_readdata_out, seed;
	logic [3:0]  avs_byteenable_in, shared_tx_count_in, ctl_tx_count_in, tok_ep_in;
	logic [1:0]  tok_kind_in;
	logic        tok_valid_in, rx_byte_valid_in, rx_done_in, rx_data1_in, tx_ack_in, tx_ready_in;
	logic [7:0]  rx_byte_in, tx_byte_out, b [8];
	logic        shared_buffer_target_select_in, shared_tx_enable_in, shared_tx_done_in;
	logic        ctl_tx_enable_in, ctl_rx_enable_in, hs_valid_out, tx_valid_out, tx_last_out;
	resp_t       hs_code_out;
	logic [31:0] exp_q [$], msk_q [$];
	logic [7:0]  tx_q [$];
	resp_t       hs_q [$];
	int          err_count, checks;
	usb_device_endpoint_status_ctrl usb_device_endpoint_status_ctrl_i (.*);
	usb_host_model usb_host_model_i (
		.sys_clk_in(sys_clk_in), .slow_in(slow), .tok_valid_out(tok_valid_in), .tok_kind_out(tok_kind_in),
		.tok_ep_out(tok_ep_in), .rx_byte_valid_out(rx_byte_valid_in), .rx_byte_out(rx_byte_in),
		.rx_done_out(rx_done_in), .rx_data1_out(rx_data1_in), .tx_ack_out(tx_ack_in), .tx_ready_out(tx_ready_in));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : compare
	task automatic compare_hs(input resp_t got, input resp_t exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t handshake %0d expected %0d", $time, got, exp);
		end
	endtask : compare_hs
	task automatic compare_tx(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t tx byte %h expected %h", $time, got, exp);
		end
	endtask : compare_tx
	task automatic end_of_test();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		avs_read_in      <= !w;
		avs_write_in     <= w;
		avs_address_in   <= a;
		avs_writedata_in <= d;
		do @(posedge sys_clk_in); while (avs_waitrequest_out);
		avs_read_in      <= 1'b0;
		avs_write_in     <= 1'b0;
		avs_writedata_in <= ~d;
	endtask : bus
	task automatic rd_reg(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd_reg
	task automatic tok(input logic [1:0] k, input logic [3:0] e, input resp_t r);
		if (r != RESP_NONE)
			hs_q.push_back(r);
		usb_host_model_i.token(k, e);
	endtask : tok
	// monitor compares each result against the oldest note
	always @(posedge sys_clk_in) begin
		if (avs_read_in && !avs_waitrequest_out)
			compare(avs_readdata_out & msk_q.pop_front(), exp_q.pop_front());
		if (hs_valid_out)
			compare_hs(hs_code_out, hs_q.size() ? hs_q.pop_front() : RESP_NONE);
		if (tx_valid_out && tx_ready_in) begin
			compare(32'(tx_last_out), 32'(tx_q.size() == 1));
			compare_tx(tx_byte_out, tx_q.size() ? tx_q.pop_front() : 8'hxx);
		end
	end
	initial begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		repeat (5000) @(posedge sys_clk_in);
		err_count++;
		$display("ERROR %0t timeout", $time);
		end_of_test();
	end
	initial begin
		{rst_in, avs_read_in, avs_write_in, slow, avs_address_in, avs_writedata_in} = {4'b1000, 39'h0};
		{shared_buffer_target_select_in, shared_tx_enable_in, shared_tx_done_in} = 3'b000;
		{ctl_tx_enable_in, ctl_rx_enable_in, avs_byteenable_in} = 6'b00_1111;
		{shared_tx_count_in, ctl_tx_count_in, seed} = {4'h2, 4'hc, 32'hef46_aa08};
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_reg(OFF_EP_ENABLE_STALL, 8'h00, 8'hff);
		rd_reg(OFF_DEVICE_STATUS, 8'h00, 8'hf0);
		rd_reg(7'h7c, 8'h00, '1);
		tok(TOK_IN, EP_CTL, RESP_NAK);
		tok(TOK_OUT, EP_CTL, RESP_NAK);
		tok(TOK_OUT, 4'h3, RESP_NONE);
		$display("reset and refusals done");
		shared_tx_enable_in <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			b[i] = 8'(rnd());
			bus(1'b1, OFF_SHARED_BUF + 7'(4 * i), {24'h0, b[i]});
		end
		rd_reg(OFF_SHARED_BUF, 8'h00, '1);
		tok(TOK_IN, EP_ONE, RESP_NONE);
		tok(TOK_IN, EP_TWO, RESP_NONE);
		bus(1'b1, OFF_EP_ENABLE_STALL, 8'hc0);
		tok(TOK_IN, EP_TWO, RESP_NAK);
		for (int s = 0; s < 2; s++) begin
			shared_buffer_target_select_in <= s[0];
			slow <= 1'(rnd());
			tx_q.push_back(b[0]);
			tx_q.push_back(b[1]);
			tok(TOK_IN, s[0] ? EP_TWO : EP_ONE, RESP_DATA);
			while (tx_q.size()) @(posedge sys_clk_in);
		end
		shared_tx_done_in <= 1'b1;
		tok(TOK_IN, EP_TWO, RESP_NAK);
		bus(1'b1, OFF_EP_ENABLE_STALL, 8'hf0);
		avs_byteenable_in <= 4'he;
		bus(1'b1, OFF_EP_ENABLE_STALL, 8'h00);
		avs_byteenable_in <= 4'hf;
		rd_reg(OFF_EP_ENABLE_STALL, 8'hf0, 8'hff);
		for (int i = 0; i < 4; i++)
			tok(i[0] ? TOK_IN : TOK_OUT, i[1] ? EP_TWO : EP_ONE, RESP_STALL);
		$display("shared endpoints done");
		bus(1'b1, OFF_IRQ_MASK, 8'h01);
		for (int i = 0; i < 8; i++) begin
			b[i] = 8'(rnd());
			tx_q.push_back(b[i]);
			bus(1'b1, OFF_CTL_BUF + 7'(4 * i), {24'h0, b[i]});
		end
		ctl_tx_enable_in <= 1'b1;
		tok(TOK_IN, EP_CTL, RESP_DATA);
		while (tx_q.size()) @(posedge sys_clk_in);
		usb_host_model_i.ack();
		ctl_rx_enable_in <= 1'b1;
		tok(TOK_OUT, EP_CTL, RESP_ACCEPT);
		for (int i = 0; i < 3; i++)
			b[i] = 8'(rnd());
		usb_host_model_i.rx_packet(b, 3, 1'b1);
		repeat (3) @(posedge sys_clk_in);
		compare(32'(irq_out), 1);
		rd_reg(OFF_DEVICE_STATUS, 8'ha3, 8'hff);
		for (int i = 0; i < 3; i++)
			rd_reg(OFF_CTL_BUF + 7'(4 * i), b[i], 8'hff);
		rd_reg(OFF_IRQ_STATUS, 8'h07, 8'h07);
		rd_reg(OFF_IRQ_STATUS, 8'h00, 8'h07);
		compare(32'(irq_out), 0);
		tok(TOK_OUT, EP_CTL, RESP_NAK);
		bus(1'b1, OFF_DEVICE_STATUS, 8'h00);
		rd_reg(OFF_DEVICE_STATUS, 8'ha3, 8'hff);
		bus(1'b1, OFF_DEVICE_STATUS, 8'h10);
		rd_reg(OFF_DEVICE_STATUS, 8'h83, 8'hff);
		bus(1'b1, OFF_CTL_FLAGS, 8'h03);
		tok(TOK_SETUP, EP_CTL, RESP_ACCEPT);
		usb_host_model_i.rx_packet(b, 2, 1'b0);
		rd_reg(OFF_DEVICE_STATUS, 8'h42, 8'hff);
		// mid-run reset: count survives, controls and irq drop
		rst_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		rd_reg(OFF_DEVICE_STATUS, 8'h02, 8'hff);
		rd_reg(OFF_EP_ENABLE_STALL, 8'h00, 8'hff);
		compare(32'(irq_out), 0);
		repeat (4) @(posedge sys_clk_in);
		compare(exp_q.size() + hs_q.size() + tx_q.size(), 0);
		$display("control endpoint done");
		end_of_test();
	end
endmodule : test_usb_device_endpoint_status_ctrl
bind usb_device_endpoint_status_ctrl usb_device_endpoint_status_ctrl_checker usb_device_endpoint_status_ctrl_checker_i (.*);
